// ---- rtl/cpuag_core.sv ----
// Operand and branch address generator of the 8-bit core.
// Contract
// RULE_01: Wait state adds two or four cycles.
// RULE_02: Registers 26 to 31 are pointers X,Y,Z.
// RULE_03: Direct addressing reaches the whole data space.
// RULE_04: All modes reach registers, I/O, SRAM.
// RULE_05: Displacement reaches 63 locations past Y/Z.
// RULE_06: Displacement adds unsigned six-bit field.
// RULE_07: Auto modes write updated pointer back.
// RULE_08: Register direct reads destination register.
// RULE_09: Direct form is two words, 16-bit address.
// RULE_10: Plain indirect uses pointer unchanged.
// RULE_11: Pointer jump and call load Z.
// RULE_12: Relative branch goes to PC+k+1.
// RULE_13: Separate 512-byte nonvolatile byte space.
// RULE_14: Core runs from undivided system clock.
// RULE_15: Fetch overlaps execution of current instruction.
// RULE_16: Decrement before access, increment after.
// RULE_17: Registers lowest, then I/O, SRAM, external.
`timescale 1ns/1ps
`default_nettype none

module cpuag_core
  import cpuag_pkg::*;
(
  input wire logic ref_clk, // System clock, used undivided.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic op_valid, // Decoded operation offered.
  input wire cpuag_op_t op, // Decoded operation.
  output logic op_ready, // Operation taken when high with op_valid.
  input wire logic ext_wait_en, // External SRAM wait state enabled.
  output cpuag_mem_t mem, // Data memory request.
  input wire logic [7:0] mem_rdata, // Data memory read byte.
  output logic result_valid, // Loaded or read operand ready, one cycle.
  output logic [7:0] result_data, // Loaded or read operand.
  output logic [PC_W-1:0] pc, // Program counter.
  output logic [PC_W-1:0] link_pc, // Return address of the last call.
  output logic fetch_en, // Next instruction fetch request.
  output logic [PC_W-1:0] fetch_addr // Next instruction fetch address.
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0] regs_r [NUM_REGS]; // Working register file.
  cpuag_state_t state_r; // Sequencer state.
  logic [2:0] cnt_r; // Remaining extra cycles.
  logic pend_load_r; // A data load completes at the end of the access.
  logic pend_nvm_r; // A nonvolatile read completes next cycle.
  logic [4:0] pend_dst_r; // Destination of the pending load.
  logic acc; // Operation taken this cycle.
  logic xfer; // Operation is a data transfer.
  logic [15:0] base; // Selected pointer value.
  logic [15:0] zval; // Z pointer value.
  logic [15:0] ea; // Effective data address.
  logic [15:0] ptr_new; // Updated pointer value.
  logic [7:0] rd_val; // Destination register value.
  logic [7:0] rr_val; // Source register value.
  logic in_regs; // Address falls in the register file.
  logic fin; // Last cycle of a memory load access.
  logic [7:0] nvm_rdata; // Nonvolatile read byte.
  logic nvm_we; // Nonvolatile write strobe.
  logic nvm_re; // Nonvolatile read strobe.

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Low register index of a pointer pair.
  function automatic logic [4:0] ptr_lo(input cpuag_ptr_t p);
    logic [4:0] idx;
    idx = PTR_X_LO;
    if (p == PTR_Y) begin
      idx = PTR_Y_LO;
    end else if (p == PTR_Z) begin
      idx = PTR_Z_LO;
    end
    return idx;
  endfunction : ptr_lo

  // Operation kinds that move a byte through the data space.
  function automatic logic is_xfer(input cpuag_kind_t k);
    return (k == K_DATA_DIRECT) || (k == K_IND) || (k == K_IND_DISP) ||
           (k == K_IND_PREDEC) || (k == K_IND_POSTINC);
  endfunction : is_xfer

  // ---------------------------------------------------------------
  // Address generation
  // ---------------------------------------------------------------
  // Forms the effective address and the updated pointer value.
  always_comb begin
    // RULE_02: pointer pairs in registers
    base = {regs_r[ptr_lo(op.ptr) + 5'd1], regs_r[ptr_lo(op.ptr)]};
    zval = {regs_r[PTR_Z_LO + 5'd1], regs_r[PTR_Z_LO]};
    rd_val = regs_r[op.dst];
    rr_val = regs_r[op.source_register];
    ea = base;
    unique case (op.kind)
      // RULE_03: full 16-bit reach
      K_DATA_DIRECT: ea = op.word2;
      // RULE_05: 63 locations past base
      // RULE_06: unsigned six-bit displacement
      K_IND_DISP: ea = base + {10'h000, op.disp};
      // RULE_16: decrement before access
      K_IND_PREDEC: ea = base - 16'h0001;
      // RULE_10: pointer used unchanged
      default: ea = base;
    endcase
    // RULE_16: post-increment uses old value for access
    ptr_new = (op.kind == K_IND_PREDEC) ? (base - 16'h0001) : (base + 16'h0001);
  end

  // RULE_17: registers lowest in the map
  assign in_regs = (ea < IO_BASE);
  assign xfer = is_xfer(op.kind);
  assign acc = op_valid && (state_r == ST_IDLE);
  assign op_ready = (state_r == ST_IDLE);
  assign fin = pend_load_r && (((state_r == ST_ACCESS) && (cnt_r == 3'h0)) ||
                               ((state_r == ST_WAIT) && (cnt_r == 3'h1)));

  // RULE_15: fetch runs while current operation executes
  assign fetch_en = (state_r == ST_IDLE);
  // RULE_14: same undivided clock drives fetch and execute
  assign fetch_addr = pc;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Steps through memory access and wait-state stalls.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (acc && ((xfer && !in_regs) || (op.kind == K_NVM))) begin
            state_r <= ST_ACCESS;
            // RULE_01: two extra cycles per external transfer
            cnt_r <= (xfer && (ea >= EXT_BASE) && ext_wait_en) ? XFER_EXTRA : 3'h0;
          end else if (acc && ext_wait_en && ((op.kind == K_PTR_CALL) || (op.kind == K_REL_CALL) ||
                                              (op.kind == K_RETURN) || (op.kind == K_INT_ENTRY))) begin
            // RULE_01: four extra cycles for stack traffic
            state_r <= ST_WAIT;
            cnt_r <= STACK_EXTRA;
          end
        end
        ST_ACCESS: begin
          state_r <= (cnt_r == 3'h0) ? ST_IDLE : ST_WAIT;
        end
        ST_WAIT: begin
          if (cnt_r == 3'h1) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          cnt_r <= 3'h0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  // Advances past each operation or loads a branch target.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc <= PC_RESET;
      link_pc <= PC_RESET;
    end else if (acc) begin
      unique case (op.kind)
        // RULE_11: load PC from Z
        K_PTR_JUMP, K_PTR_CALL: pc <= zval[PC_W-1:0];
        // RULE_12: PC plus offset plus one
        K_REL_JUMP, K_REL_CALL: pc <= pc + op.rel + 12'h001;
        K_RETURN, K_INT_ENTRY: pc <= op.word2[PC_W-1:0];
        // RULE_09: direct form spans two words
        K_DATA_DIRECT: pc <= pc + 12'h002;
        default: pc <= pc + 12'h001;
      endcase
      if ((op.kind == K_PTR_CALL) || (op.kind == K_REL_CALL)) begin
        link_pc <= pc + 12'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  // Holds pointer write-back, register-region transfers and load results.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= 8'h00;
      end
    end else begin
      if (acc && ((op.kind == K_IND_PREDEC) || (op.kind == K_IND_POSTINC))) begin
        // RULE_07: write updated pointer pair back
        regs_r[ptr_lo(op.ptr)] <= ptr_new[7:0];
        regs_r[ptr_lo(op.ptr) + 5'd1] <= ptr_new[15:8];
      end
      if (acc && (op.kind == K_REG_DIRECT) && op.store) begin
        regs_r[op.dst] <= op.word2[7:0];
      end
      // RULE_04: registers reached through every mode
      if (acc && xfer && in_regs) begin
        if (op.store) begin
          regs_r[ea[4:0]] <= rr_val;
        end else begin
          regs_r[op.dst] <= regs_r[ea[4:0]];
        end
      end
      if (fin) begin
        regs_r[pend_dst_r] <= mem_rdata;
      end
      if (pend_nvm_r && (state_r == ST_ACCESS)) begin
        regs_r[pend_dst_r] <= nvm_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Memory request
  // ---------------------------------------------------------------
  // Issues one request per access to I/O and SRAM; the address stands after.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem <= '0;
      pend_load_r <= 1'b0;
      pend_nvm_r <= 1'b0;
      pend_dst_r <= 5'h00;
    end else begin
      mem.req <= 1'b0;
      mem.we <= 1'b0;
      if (fin || (state_r == ST_ACCESS && cnt_r == 3'h0)) begin
        pend_load_r <= 1'b0;
      end
      if (state_r == ST_ACCESS) begin
        pend_nvm_r <= 1'b0;
      end
      // RULE_04: I/O and SRAM reached through the port
      if (acc && xfer && !in_regs) begin
        mem.req <= 1'b1;
        mem.we <= op.store;
        mem.addr <= ea;
        mem.wdata <= rr_val;
        pend_load_r <= !op.store;
        pend_dst_r <= op.dst;
      end
      if (acc && (op.kind == K_NVM)) begin
        pend_nvm_r <= !op.store;
        pend_dst_r <= op.dst;
      end
    end
  end

  // ---------------------------------------------------------------
  // Result
  // ---------------------------------------------------------------
  // Presents each read operand for one cycle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      result_valid <= 1'b0;
      result_data <= 8'h00;
    end else begin
      result_valid <= 1'b0;
      // RULE_08: operand from destination register
      if (acc && (op.kind == K_REG_DIRECT) && !op.store) begin
        result_valid <= 1'b1;
        result_data <= rd_val;
      end else if (acc && xfer && in_regs && !op.store) begin
        result_valid <= 1'b1;
        result_data <= regs_r[ea[4:0]];
      end else if (fin) begin
        result_valid <= 1'b1;
        result_data <= mem_rdata;
      end else if (pend_nvm_r && (state_r == ST_ACCESS)) begin
        result_valid <= 1'b1;
        result_data <= nvm_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Nonvolatile store
  // ---------------------------------------------------------------
  assign nvm_we = acc && (op.kind == K_NVM) && op.store;
  assign nvm_re = acc && (op.kind == K_NVM) && !op.store;

  // RULE_13: separate byte-wide data space
  cpuag_nvm_bytes u_nvm (
    .ref_clk(ref_clk),
    .rst(rst),
    .addr(op.word2[NVM_AW-1:0]),
    .wdata(rr_val),
    .we(nvm_we),
    .re(nvm_re),
    .rdata(nvm_rdata)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic ptr_safe;
  assign ptr_safe = (op.dst < PTR_X_LO) && (op.source_register < PTR_X_LO);

  direct_addr_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_09
    acc && (op.kind == K_DATA_DIRECT) && !in_regs |=> mem.req && (mem.addr == $past(op.word2)))
    else $error("direct address not taken from second word");

  disp_addr_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_05
    acc && (op.kind == K_IND_DISP) && !in_regs |=> mem.addr == $past(base) + {10'h000, $past(op.disp)})
    else $error("displacement address wrong");

  plain_ind_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_10
    acc && (op.kind == K_IND) && !in_regs |=> mem.addr == $past(base))
    else $error("plain indirect address modified");

  predec_addr_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_16
    acc && (op.kind == K_IND_PREDEC) && !in_regs |=> mem.addr == $past(base) - 16'h0001)
    else $error("pre-decrement not applied before access");

  postinc_wb_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
    acc && (op.kind == K_IND_POSTINC) && ptr_safe && !in_regs |=>
      ({regs_r[$past(ptr_lo(op.ptr)) + 5'd1], regs_r[$past(ptr_lo(op.ptr))]} == $past(base) + 16'h0001) &&
      (mem.addr == $past(base)))
    else $error("post-increment write-back wrong");

  ptr_jump_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_11
    acc && ((op.kind == K_PTR_JUMP) || (op.kind == K_PTR_CALL)) |=> pc == $past(zval[PC_W-1:0]))
    else $error("pointer branch did not load Z");

  rel_jump_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_12
    acc && ((op.kind == K_REL_JUMP) || (op.kind == K_REL_CALL)) |=> pc == $past(pc) + $past(op.rel) + 12'h001)
    else $error("relative branch target wrong");

  ext_stall_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
    acc && xfer && (ea >= EXT_BASE) && ext_wait_en |=> !op_ready [*3] ##1 op_ready)
    else $error("external transfer stall not two extra cycles");

  call_stall_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
    acc && ext_wait_en && ((op.kind == K_PTR_CALL) || (op.kind == K_RETURN)) |=> !op_ready [*4] ##1 op_ready)
    else $error("call or return stall not four extra cycles");

  reg_direct_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_08
    acc && (op.kind == K_REG_DIRECT) && !op.store |=> result_valid && (result_data == $past(rd_val)))
    else $error("register direct operand wrong");

  fetch_overlap_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_15
    acc && (op.kind == K_NOP) |=> fetch_en && (fetch_addr == $past(pc) + 12'h001))
    else $error("fetch not overlapped with execution");

endmodule : cpuag_core
`default_nettype wire

// ---- rtl/cpuag_pkg.sv ----
// Package with the data space map, operation kinds and carriers for the address generator.
package cpuag_pkg;

  // ---------------------------------------------------------------
  // Data space map
  // ---------------------------------------------------------------
  // Working registers sit lowest, then I/O, internal SRAM, external SRAM.
  localparam logic [15:0] REG_BASE = 16'h0000;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] SRAM_BASE = 16'h0060;
  localparam logic [15:0] EXT_BASE = 16'h0260;
  localparam int NUM_REGS = 32;

  // Low register index of each pointer pair.
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;

  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  // Extra cycles added while the external wait state is enabled.
  localparam logic [2:0] XFER_EXTRA = 3'h2;
  localparam logic [2:0] STACK_EXTRA = 3'h4;

  // Program counter width and reset value (4K words).
  localparam int PC_W = 12;
  localparam logic [11:0] PC_RESET = 12'h000;

  // Nonvolatile byte store size.
  localparam int NVM_DEPTH = 512;
  localparam int NVM_AW = 9;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  // Operation kinds handed over by the instruction decoder.
  typedef enum logic [3:0] {
    K_NOP         = 4'h0,
    K_REG_DIRECT  = 4'h1,
    K_DATA_DIRECT = 4'h2,
    K_IND         = 4'h3,
    K_IND_DISP    = 4'h4,
    K_IND_PREDEC  = 4'h5,
    K_IND_POSTINC = 4'h6,
    K_PTR_JUMP    = 4'h7,
    K_PTR_CALL    = 4'h8,
    K_REL_JUMP    = 4'h9,
    K_REL_CALL    = 4'hA,
    K_RETURN      = 4'hB,
    K_INT_ENTRY   = 4'hC,
    K_NVM         = 4'hD
  } cpuag_kind_t;

  // Pointer pair selection.
  typedef enum logic [1:0] {
    PTR_X = 2'b00,
    PTR_Y = 2'b01,
    PTR_Z = 2'b10
  } cpuag_ptr_t;

  // One decoded operation.
  typedef struct packed {
    cpuag_kind_t kind;
    cpuag_ptr_t ptr;
    logic store;
    logic [4:0] dst;
    logic [4:0] source_register;
    logic [5:0] disp;
    logic [15:0] word2;
    logic [11:0] rel;
  } cpuag_op_t;

  // Data memory request toward I/O and SRAM.
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cpuag_mem_t;

  // Control state of the sequencer.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01,
    ST_WAIT   = 2'b10
  } cpuag_state_t;

endpackage : cpuag_pkg

// ---- rtl/cpuag_nvm_bytes.sv ----
// Byte-wide nonvolatile data store kept as a separate data space.
`timescale 1ns/1ps
`default_nettype none

module cpuag_nvm_bytes
  import cpuag_pkg::*;
(
  input wire logic ref_clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [NVM_AW-1:0] addr, // Byte address.
  input wire logic [7:0] wdata, // Byte to write.
  input wire logic we, // Write strobe, one cycle.
  input wire logic re, // Read strobe, one cycle.
  output logic [7:0] rdata // Byte read, valid the cycle after re.
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Flip-flop array addressed by index; contents are not cleared by reset.
  logic [7:0] mem_r [NVM_DEPTH];

  // RULE_13: byte wise write
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem_r[addr] <= wdata;
    end
  end

  // RULE_13: byte wise read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (re) begin
      rdata <= mem_r[addr];
    end
  end

endmodule : cpuag_nvm_bytes
`default_nettype wire

// ---- sim/cpuag_mem_model.sv ----
// Behavioural data memory that answers the address generator's requests.
`timescale 1ns/1ps
`default_nettype none

module cpuag_mem_model
  import cpuag_pkg::*;
(
  input wire logic ref_clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire cpuag_mem_t mem, // Request from the core.
  output logic [7:0] mem_rdata // Read byte back to the core.
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] arr [0:65535]; // Whole 64K data space with a known fill.
  logic [1:0] hold_r; // Cycles left in which the read byte stands.
  logic [7:0] last_r; // Last byte shown, inverted once the line is released.

  // Each byte starts as a mix of its address halves.
  initial begin
    for (int i = 0; i < 65536; i++) begin
      arr[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
    end
  end

  // Writes land on the request edge; the read byte stands through two wait cycles.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_r <= 2'h0;
    end else if (mem.req) begin
      hold_r <= 2'h2;
      if (mem.we) begin
        arr[mem.addr] <= mem.wdata;
      end
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end
  end

  // Remember the shown byte so a released line never repeats it.
  always @(posedge ref_clk) begin
    last_r <= mem_rdata;
  end

  // Outside an access the line shows the inverse of the last byte.
  assign mem_rdata = (mem.req || hold_r != 2'h0) ? arr[mem.addr] : ~last_r;
endmodule : cpuag_mem_model
`default_nettype wire

// ---- sim/cpu_address_generation_tb.sv ----
// Self-checking testbench of the operand and branch address generator.
`timescale 1ns/1ps
`default_nettype none

module cpu_address_generation_tb
  import cpuag_pkg::*;
;
  // One table row: the operation, then the expected answer (-1 skips a field).
  typedef struct {
    cpuag_op_t o;
    logic w;
    int lat;
    logic [7:0] d;
    int a;
    int busy;
    int pcx;
    int lk;
  } cpuag_row_t;

  logic ref_clk, rst, op_valid, ext_wait_en, op_ready, result_valid, fetch_en;
  cpuag_op_t op;
  cpuag_mem_t mem;
  logic [7:0] mem_rdata, result_data, data_g;
  logic [PC_W-1:0] pc, link_pc, fetch_addr;
  logic [15:0] addr_g;
  logic we_g;
  int failures, total_checks, lat_g, busy_g, nreq_g;
  cpuag_row_t rows[$];

  cpuag_core dut (.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid), .op(op), .op_ready(op_ready),
    .ext_wait_en(ext_wait_en), .mem(mem), .mem_rdata(mem_rdata), .result_valid(result_valid),
    .result_data(result_data), .pc(pc), .link_pc(link_pc), .fetch_en(fetch_en), .fetch_addr(fetch_addr));
  cpuag_mem_model u_mem (.ref_clk(ref_clk), .rst(rst), .mem(mem), .mem_rdata(mem_rdata));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Compares a design value, widened to 16 bits, with case equality.
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  // Compares a count measured by the bench.
  task automatic check_int(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_int

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  function automatic cpuag_op_t mk(cpuag_kind_t k, cpuag_ptr_t p, logic s, logic [4:0] dst, logic [4:0] src,
    logic [5:0] dp, logic [15:0] w2, logic [11:0] rel);
    mk = '{k, p, s, dst, src, dp, w2, rel};
  endfunction : mk

  function automatic cpuag_row_t rw(cpuag_kind_t k, cpuag_ptr_t p, logic s, logic [4:0] dst, logic [4:0] src,
    logic [5:0] dp, logic [15:0] w2, logic [11:0] rel, logic w, int lat, logic [7:0] d, int a, int busy,
    int pcx, int lk);
    rw = '{mk(k, p, s, dst, src, dp, w2, rel), w, lat, d, a, busy, pcx, lk};
  endfunction : rw

  // Offers one operation, holds it until taken, then watches six cycles.
  task automatic run_op(input cpuag_op_t o, input logic w);
    ext_wait_en = w;
    op = o;
    op_valid = 1'b1;
    for (int g = 0; g < 20 && op_ready !== 1'b1; g++) @(posedge ref_clk) #1;
    check_val({15'h0000, op_ready}, 16'h0001);
    @(posedge ref_clk);
    #1;
    op_valid = 1'b0;
    lat_g = 0;
    busy_g = 0;
    nreq_g = 0;
    for (int k = 1; k <= 6; k++) begin
      if (result_valid === 1'b1 && lat_g == 0) begin
        lat_g = k;
        data_g = result_data;
      end
      if (mem.req === 1'b1) begin
        nreq_g++;
        addr_g = mem.addr;
        we_g = mem.we;
      end
      if (op_ready !== 1'b1) busy_g++;
      if (k < 6) begin
        @(posedge ref_clk);
        #1;
      end
    end
  endtask : run_op

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // The whole run needs well under 500 cycles.
  initial begin
    #100000;
    failures++;
    end_of_test();
  end

  initial begin
    logic [7:0] pv [6];
    pv = '{8'h00, 8'h01, 8'hFF, 8'h01, 8'h60, 8'h02};
    rst = 1'b1;
    op_valid = 1'b0;
    ext_wait_en = 1'b0;
    op = '0;
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    // X = 0x0100, Y = 0x01FF, Z = 0x0260, R5 = 0x3C.
    for (int i = 0; i < 6; i++) begin
      run_op(mk(K_REG_DIRECT, PTR_X, 1'b1, 26 + i, 0, 0, {8'h00, pv[i]}, 0), 1'b0);
    end
    run_op(mk(K_REG_DIRECT, PTR_X, 1'b1, 5, 0, 0, 16'h003C, 0), 1'b0);
    rows.push_back(rw(K_REG_DIRECT, PTR_X, 0, 5, 0, 0, 0, 0, 0, 1, 8'h3C, -1, 0, -1, -1));
    rows.push_back(rw(K_IND, PTR_X, 0, 1, 0, 0, 0, 0, 0, 2, 8'hA4, 'h100, 1, -1, -1));
    rows.push_back(rw(K_IND_DISP, PTR_Y, 0, 1, 0, 6'h3F, 0, 0, 0, 2, 8'h99, 'h23E, 1, -1, -1));
    rows.push_back(rw(K_IND_POSTINC, PTR_Y, 0, 2, 0, 0, 0, 0, 0, 2, 8'h5B, 'h1FF, 1, -1, -1));
    rows.push_back(rw(K_REG_DIRECT, PTR_X, 0, 28, 0, 0, 0, 0, 0, 1, 8'h00, -1, 0, -1, -1));
    rows.push_back(rw(K_REG_DIRECT, PTR_X, 0, 29, 0, 0, 0, 0, 0, 1, 8'h02, -1, 0, -1, -1));
    rows.push_back(rw(K_IND_PREDEC, PTR_X, 0, 1, 0, 0, 0, 0, 0, 2, 8'h5A, 'h0FF, 1, -1, -1));
    rows.push_back(rw(K_REG_DIRECT, PTR_X, 0, 26, 0, 0, 0, 0, 0, 1, 8'hFF, -1, 0, -1, -1));
    rows.push_back(rw(K_REG_DIRECT, PTR_X, 0, 27, 0, 0, 0, 0, 0, 1, 8'h00, -1, 0, -1, -1));
    rows.push_back(rw(K_IND, PTR_Z, 0, 1, 0, 0, 0, 0, 0, 2, 8'hC7, 'h260, 1, -1, -1));
    rows.push_back(rw(K_IND, PTR_Z, 0, 1, 0, 0, 0, 0, 1, 4, 8'hC7, 'h260, 3, -1, -1));
    rows.push_back(rw(K_DATA_DIRECT, PTR_X, 0, 3, 0, 0, 16'hFFFF, 0, 0, 2, 8'hA5, 'hFFFF, 1, -1, -1));
    rows.push_back(rw(K_DATA_DIRECT, PTR_X, 0, 3, 0, 0, 16'h0005, 0, 0, 1, 8'h3C, -1, 0, -1, -1));
    rows.push_back(rw(K_DATA_DIRECT, PTR_X, 0, 3, 0, 0, 16'h0020, 0, 0, 2, 8'h85, 'h20, 1, -1, -1));
    rows.push_back(rw(K_DATA_DIRECT, PTR_X, 1, 0, 5, 0, 16'h0300, 0, 1, 0, 8'h00, 'h300, 3, -1, -1));
    rows.push_back(rw(K_DATA_DIRECT, PTR_X, 0, 4, 0, 0, 16'h0300, 0, 1, 4, 8'h3C, 'h300, 3, -1, -1));
    rows.push_back(rw(K_NVM, PTR_X, 1, 0, 5, 0, 16'h01FF, 0, 0, 0, 8'h00, -1, 1, -1, -1));
    rows.push_back(rw(K_NVM, PTR_X, 0, 7, 0, 0, 16'h01FF, 0, 0, 2, 8'h3C, -1, 1, -1, -1));
    rows.push_back(rw(K_DATA_DIRECT, PTR_X, 1, 0, 5, 0, 16'h0009, 0, 0, 0, 8'h00, -1, 0, -1, -1));
    rows.push_back(rw(K_REG_DIRECT, PTR_X, 0, 9, 0, 0, 0, 0, 0, 1, 8'h3C, -1, 0, -1, -1));
    rows.push_back(rw(K_PTR_JUMP, PTR_Z, 0, 0, 0, 0, 0, 0, 0, 0, 8'h00, -1, 0, 'h260, -1));
    rows.push_back(rw(K_DATA_DIRECT, PTR_X, 0, 3, 0, 0, 16'h0020, 0, 0, 2, 8'h85, 'h20, 1, 'h262, -1));
    rows.push_back(rw(K_REL_JUMP, PTR_X, 0, 0, 0, 0, 0, 12'h800, 0, 0, 8'h00, -1, 0, 'hA63, -1));
    rows.push_back(rw(K_REL_CALL, PTR_X, 0, 0, 0, 0, 0, 12'h7FF, 1, 0, 8'h00, -1, 4, 'h263, 'hA64));
    rows.push_back(rw(K_PTR_CALL, PTR_Z, 0, 0, 0, 0, 0, 0, 0, 0, 8'h00, -1, 0, 'h260, 'h264));
    rows.push_back(rw(K_RETURN, PTR_X, 0, 0, 0, 0, 16'h0123, 0, 1, 0, 8'h00, -1, 4, 'h123, -1));
    rows.push_back(rw(K_INT_ENTRY, PTR_X, 0, 0, 0, 0, 16'h0004, 0, 1, 0, 8'h00, -1, 4, 'h004, -1));
    rows.push_back(rw(K_NOP, PTR_X, 0, 0, 0, 0, 0, 0, 0, 0, 8'h00, -1, 0, 'h005, -1));
    foreach (rows[i]) begin
      run_op(rows[i].o, rows[i].w);
      check_int(lat_g, rows[i].lat);
      if (rows[i].busy >= 0) check_int(busy_g, rows[i].busy);
      if (rows[i].lat > 0) check_val({8'h00, data_g}, {8'h00, rows[i].d});
      check_int(nreq_g, (rows[i].a < 0) ? 0 : 1);
      if (rows[i].a >= 0) check_val(addr_g, rows[i].a[15:0]);
      if (rows[i].a >= 0) check_val({15'h0000, we_g}, {15'h0000, rows[i].o.store});
      if (rows[i].pcx >= 0) check_val({4'h0, pc}, rows[i].pcx[15:0]);
      if (rows[i].pcx >= 0) check_val({4'h0, fetch_addr}, rows[i].pcx[15:0]);
      if (rows[i].pcx >= 0) check_val({15'h0000, fetch_en}, 16'h0001);
      if (rows[i].lk >= 0) check_val({4'h0, link_pc}, rows[i].lk[15:0]);
    end
    // A second reset in mid-run clears the counter and the registers.
    rst = 1'b1;
    @(posedge ref_clk);
    #1;
    check_val({4'h0, pc}, 16'h0000);
    check_val({14'h0000, op_ready, fetch_en}, 16'h0003);
    check_val({14'h0000, mem.req, result_valid}, 16'h0000);
    check_val({4'h0, link_pc}, 16'h0000);
    rst = 1'b0;
    run_op(mk(K_REG_DIRECT, PTR_X, 1'b0, 5, 0, 0, 0, 0), 1'b0);
    check_int(lat_g, 1);
    check_val({8'h00, data_g}, 16'h0000);
    end_of_test();
  end
endmodule : cpu_address_generation_tb
`default_nettype wire
